// ===== rtl/cpm_monitor.sv
/*
 Charge protection event monitor: limit checks, event queue, protective latches,
 classic Wishbone register slave.
 Assumes measurements and channel/PWM flags come from logic on clk_sys_in;
 sense pins, self-check pins and switches are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_monitor #(
	parameter logic [32:0] OV_DLY_CYC = 33'(cpm_pkg::OV_DELAY_S * cpm_pkg::CLK_HZ),
	parameter logic [12:0] VREF_LO = 13'h0800,
	parameter logic [12:0] VREF_HI = 13'h0a00
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [3:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire cpm_pkg::cpm_meas_t meas_in,
	input wire logic cha_on_in,
	input wire logic chb_on_in,
	input wire logic pwm_min_in,
	input wire logic batt_open_in,
	input wire logic hw_trip_in,
	input wire logic fuse_open_in,
	input wire logic diag_done_in,
	input wire logic diag_fail_in,
	input wire logic [1:0] dip_in,
	output logic evt_valid_out,
	output cpm_pkg::cpm_evt_t evt_out,
	output cpm_pkg::cpm_act_t act_out
);
	function automatic logic [12:0] pick(input logic m120, input logic [12:0] a, input logic [12:0] b);
		pick = m120 ? b : a;
	endfunction
	function automatic logic is_reg(input logic [3:0] adr, input logic [3:0] off);
		is_reg = (adr[3:2] == off[3:2]);
	endfunction
	function automatic logic [4:0] src_num(input int k);
		case (k)
			0, 1, 2, 3, 4, 5: src_num = cpm_pkg::EV_MODE;
			6: src_num = cpm_pkg::EV_CHFAIL;
			7: src_num = cpm_pkg::EV_DIAG;
			8: src_num = cpm_pkg::EV_ADC;
			9: src_num = cpm_pkg::EV_ULTRA;
			10: src_num = cpm_pkg::EV_PV1OC;
			11: src_num = cpm_pkg::EV_PVOV;
			12: src_num = cpm_pkg::EV_OUTAOC;
			13: src_num = cpm_pkg::EV_LOWSOC;
			14: src_num = cpm_pkg::EV_LOWBAT;
			15: src_num = cpm_pkg::EV_SURGE;
			default: src_num = cpm_pkg::EV_BATOV;
		endcase
	endfunction
	function automatic logic [12:0] src_data(input int k, input cpm_pkg::cpm_meas_t m);
		case (k)
			0: src_data = cpm_pkg::MD_A_ON;
			1: src_data = cpm_pkg::MD_A_OFF;
			2: src_data = cpm_pkg::MD_B_ON;
			3: src_data = cpm_pkg::MD_B_OFF;
			4: src_data = cpm_pkg::MD_A_OPEN;
			5: src_data = cpm_pkg::MD_B_OPEN;
			8: src_data = m.vref;
			9, 14, 16: src_data = m.batt_v;
			10: src_data = m.pv1_i;
			11: src_data = (m.pv_a_v > m.pv_b_v) ? m.pv_a_v : m.pv_b_v;
			12: src_data = m.outa_i;
			13: src_data = {6'h00, m.soc};
			default: src_data = 13'h0000;
		endcase
	endfunction
	function automatic logic [4:0] first_idx(input logic [16:0] p);
		first_idx = 5'h00;
		for (int i = cpm_pkg::NSRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				first_idx = 5'(i);
			end
		end
	endfunction

	// Pin synchronisers
	logic [6:0] sync1;
	logic [6:0] sync2;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync1 <= 7'h00;
			sync2 <= 7'h00;
		end else begin
			sync1 <= {dip_in, diag_fail_in, diag_done_in, fuse_open_in, hw_trip_in, batt_open_in};
			sync2 <= sync1;
		end
	end
	logic batt_open;
	logic hw_trip;
	logic fuse_open;
	logic diag_done;
	logic diag_fail;
	logic [1:0] dip;
	assign {dip, diag_fail, diag_done, fuse_open, hw_trip, batt_open} = sync2;

	// Wishbone slave
	logic m120;
	logic ext;
	logic restart;
	logic [3:0] step;
	logic [6:0] recon;
	logic wr;
	assign wr = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			m120 <= 1'b0;
			ext <= 1'b0;
			step <= cpm_pkg::STEP_RST;
			recon <= cpm_pkg::RECON_RST;
			restart <= 1'b0;
		end else begin
			restart <= wr & is_reg(wb_adr_in, cpm_pkg::REG_CTRL) & wb_sel_in[0] & wb_dat_in[2];
			if (wr && is_reg(wb_adr_in, cpm_pkg::REG_CTRL)) begin
				if (wb_sel_in[0]) begin
					m120 <= wb_dat_in[0];
					ext <= wb_dat_in[1];
				end
				if (wb_sel_in[1]) begin
					step <= (wb_dat_in[11:8] > cpm_pkg::STEP_MAX) ? cpm_pkg::STEP_MAX : wb_dat_in[11:8];
				end
				if (wb_sel_in[2]) begin
					recon <= wb_dat_in[22:16];
				end
			end
		end
	end

	// Limit comparisons
	cpm_pkg::cpm_state_t state;
	logic [32:0] ov_cnt;
	logic soc_low;
	logic [6:0] soc_thr;
	logic [6:0] soc_hi;
	logic c_ultra;
	logic c_low;
	logic c_ovd;
	logic c_ovi;
	logic c_pvov;
	logic c_pv1oc;
	logic c_outaoc;
	logic c_adc;
	logic c_diag;
	logic c_batov;
	always_comb begin
		c_ultra = meas_in.batt_v < pick(m120, cpm_pkg::BV_ULTRA_48, cpm_pkg::BV_ULTRA_120);
		c_low = meas_in.batt_v < pick(m120, cpm_pkg::BV_LOW_48, cpm_pkg::BV_LOW_120);
		c_ovd = meas_in.batt_v > pick(m120, cpm_pkg::BV_OVD_48, cpm_pkg::BV_OVD_120);
		c_ovi = meas_in.batt_v > pick(m120, cpm_pkg::BV_OVI_48, cpm_pkg::BV_OVI_120);
		c_pvov = (meas_in.pv_a_v > cpm_pkg::PV_OV) | (meas_in.pv_b_v > cpm_pkg::PV_OV);
		c_pv1oc = meas_in.pv1_i > cpm_pkg::PV1_OC;
		c_outaoc = meas_in.outa_i > cpm_pkg::OUTA_OC;
		c_adc = (meas_in.vref < VREF_LO) | (meas_in.vref > VREF_HI);
		c_diag = (state == cpm_pkg::ST_BOOT) & diag_done & diag_fail;
		c_batov = c_ovi | (ov_cnt == OV_DLY_CYC);
		if (ext) begin
			soc_thr = 7'(step * cpm_pkg::SOC_STEP);
			soc_hi = recon;
		end else begin
			case (dip)
				2'b01: soc_thr = cpm_pkg::SOC_50;
				2'b10: soc_thr = cpm_pkg::SOC_75;
				default: soc_thr = cpm_pkg::SOC_25;
			endcase
			soc_hi = soc_thr + cpm_pkg::SOC_HYST;
		end
	end
	// Dwell counter, saturates at the limit
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ov_cnt <= 33'h0;
		end else if (!c_ovd) begin
			ov_cnt <= 33'h0;
		end else if (ov_cnt != OV_DLY_CYC) begin
			ov_cnt <= ov_cnt + 33'h1;
		end
	end
	// Charge hysteresis
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			soc_low <= 1'b0;
		end else if (meas_in.soc <= soc_thr) begin
			soc_low <= 1'b1;
		end else if (meas_in.soc >= soc_hi) begin
			soc_low <= 1'b0;
		end
	end

	// Event sources, capture and queue
	logic [16:0] cond;
	logic [16:0] cond_q;
	logic [16:0] rise;
	logic [16:0] pend;
	logic [16:0] grant;
	logic [12:0] data_q [cpm_pkg::NSRC];
	logic [4:0] gidx;
	logic [7:0] evt_cnt;
	assign cond = {c_batov, fuse_open, c_low, soc_low, c_outaoc, c_pvov, c_pv1oc, c_ultra, c_adc,
		c_diag, hw_trip, batt_open & chb_on_in, batt_open & cha_on_in, ~chb_on_in, chb_on_in,
		~cha_on_in, cha_on_in};
	assign rise = cond & ~cond_q;
	assign grant = pend & (~pend + 17'h1);
	assign gidx = first_idx(pend);
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cond_q <= cpm_pkg::COND_RST;
			pend <= 17'h0;
		end else begin
			cond_q <= cond;
			pend <= (pend & ~grant) | rise;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int k = 0; k < cpm_pkg::NSRC; k++) begin
				data_q[k] <= 13'h0;
			end
		end else begin
			for (int k = 0; k < cpm_pkg::NSRC; k++) begin
				if (rise[k] && !(pend[k] && !grant[k])) begin
					data_q[k] <= src_data(k, meas_in);
				end
			end
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			evt_valid_out <= 1'b0;
			evt_out <= '0;
			evt_cnt <= 8'h00;
		end else begin
			evt_valid_out <= |pend;
			if (|pend) begin
				evt_out.num <= src_num(int'(gidx));
				evt_out.data <= data_q[gidx];
				evt_cnt <= evt_cnt + 8'h01;
			end
		end
	end

	// Protective latches, set wins over restart
	cpm_pkg::cpm_act_t flt;
	logic arm_trip;
	logic arm_ilim;
	logic fire_trip;
	logic fire_ilim;
	assign fire_trip = (arm_trip | c_pvov | c_outaoc) & pwm_min_in;
	assign fire_ilim = (arm_ilim | c_pv1oc) & pwm_min_in;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arm_trip <= 1'b0;
			arm_ilim <= 1'b0;
		end else begin
			arm_trip <= (c_pvov | c_outaoc) | (arm_trip & ~pwm_min_in & ~restart);
			arm_ilim <= c_pv1oc | (arm_ilim & ~pwm_min_in & ~restart);
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			flt <= '0;
		end else begin
			flt.batt_open <= c_diag | c_ultra | fire_trip | c_batov | (flt.batt_open & ~restart);
			flt.load_open <= c_batov | (flt.load_open & ~restart);
			flt.ilim <= fire_ilim | (flt.ilim & ~restart);
			flt.shutdown <= c_diag | c_ultra | fire_trip | fire_ilim | c_batov
				| (flt.shutdown & ~restart);
			flt.alarm <= c_diag | c_ultra | fire_trip | fire_ilim | c_batov
				| (flt.alarm & ~restart);
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			act_out <= '0;
		end else begin
			act_out <= flt;
			act_out.load_open <= flt.load_open | soc_low;
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= cpm_pkg::ST_BOOT;
		end else begin
			case (state)
				cpm_pkg::ST_BOOT: begin
					if (diag_done) begin
						state <= diag_fail ? cpm_pkg::ST_HALT : cpm_pkg::ST_RUN;
					end
				end
				cpm_pkg::ST_RUN: begin
					if (restart) begin
						state <= cpm_pkg::ST_BOOT;
					end else if (flt.shutdown) begin
						state <= cpm_pkg::ST_HALT;
					end
				end
				cpm_pkg::ST_HALT: begin
					if (restart) begin
						state <= cpm_pkg::ST_BOOT;
					end
				end
				default: state <= cpm_pkg::ST_BOOT;
			endcase
		end
	end

	// Register read
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wb_dat_out <= 32'h0;
		end else if (is_reg(wb_adr_in, cpm_pkg::REG_CTRL)) begin
			wb_dat_out <= {9'h0, recon, 4'h0, step, 6'h0, ext, m120};
		end else if (is_reg(wb_adr_in, cpm_pkg::REG_STAT)) begin
			wb_dat_out <= {9'h0, soc_thr, 6'h0, state == cpm_pkg::ST_HALT,
				state == cpm_pkg::ST_RUN, 1'b0, ov_cnt != 33'h0, soc_low, flt};
		end else if (is_reg(wb_adr_in, cpm_pkg::REG_EVT)) begin
			wb_dat_out <= {3'h0, evt_out.data, evt_cnt, 3'h0, evt_out.num};
		end else begin
			wb_dat_out <= 32'h0;
		end
	end

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	AST_BATOV_ACT: assert property (c_batov |-> ##2 act_out.batt_open && act_out.load_open
		&& act_out.shutdown && act_out.alarm) else $error("Over-voltage did not trip");
	AST_ULTRA_ACT: assert property (c_ultra |-> ##2 act_out.batt_open && act_out.shutdown
		&& act_out.alarm) else $error("Ultra-low did not trip");
	AST_DIAG_ACT: assert property (c_diag |-> ##2 act_out.batt_open && act_out.alarm
		&& state == cpm_pkg::ST_HALT) else $error("Self-check failure not acted on");
	AST_TRIP_WAIT: assert property ((c_pvov || c_outaoc) && pwm_min_in |-> ##2 act_out.batt_open
		&& act_out.shutdown) else $error("Trip at minimum PWM missing");
	AST_ILIM: assert property (c_pv1oc && pwm_min_in |-> ##2 act_out.ilim && act_out.alarm
		&& act_out.shutdown) else $error("Current limit missing");
	AST_LOAD_HYST: assert property (meas_in.soc <= soc_thr |-> ##2 act_out.load_open)
		else $error("Load switch not opened at low charge");
	AST_SOC_CLR: assert property (soc_low && meas_in.soc >= soc_hi && meas_in.soc > soc_thr
		|=> !soc_low) else $error("Low charge did not clear");
	AST_LATCH: assert property (flt.shutdown && !restart |=> flt.shutdown)
		else $error("Shutdown dropped without restart");
	AST_BATOV_EVT: assert property (rise[16] |-> ##[1:20] evt_valid_out
		&& evt_out.num == cpm_pkg::EV_BATOV) else $error("Over-voltage event not logged");
	AST_DLY: assert property ($rose(ov_cnt == OV_DLY_CYC) |-> $past(c_ovd) && c_batov)
		else $error("Dwell over-voltage wrong");
	COV_BATOV: cover property (c_batov ##2 act_out.load_open);
	COV_ULTRA: cover property (c_ultra ##2 act_out.shutdown);
	COV_SOC: cover property ($rose(soc_low) ##[1:20] $fell(soc_low));
	COV_RESTART: cover property (state == cpm_pkg::ST_HALT ##1 restart ##1 state == cpm_pkg::ST_BOOT);
endmodule
`default_nettype wire

// ===== rtl/cpm_pkg.sv
/*
 Constants, types and register map of the charge protection event monitor.
 Assumes measurement codes arrive already scaled: volts times 10.13, amps times 7.75.
*/
package cpm_pkg;
	localparam int VW = 13;
	localparam int NSRC = 17;
	// Battery and solar voltage limits and current limits as raw codes
	localparam logic [12:0] BV_ULTRA_48 = 13'h0cb;
	localparam logic [12:0] BV_ULTRA_120 = 13'h260;
	localparam logic [12:0] BV_LOW_48 = 13'h0cb;
	localparam logic [12:0] BV_LOW_120 = 13'h1fb;
	localparam logic [12:0] BV_OVD_48 = 13'h27e;
	localparam logic [12:0] BV_OVD_120 = 13'h63b;
	localparam logic [12:0] BV_OVI_48 = 13'h288;
	localparam logic [12:0] BV_OVI_120 = 13'h655;
	localparam logic [12:0] PV_OV = 13'h13c9;
	localparam logic [12:0] PV1_OC = 13'h0c2;
	localparam logic [12:0] OUTA_OC = 13'h193;
	// State of charge in percent
	localparam logic [6:0] SOC_25 = 7'h19;
	localparam logic [6:0] SOC_50 = 7'h32;
	localparam logic [6:0] SOC_75 = 7'h4b;
	localparam logic [6:0] SOC_HYST = 7'h0a;
	localparam logic [6:0] SOC_STEP = 7'h0a;
	localparam logic [3:0] STEP_MAX = 4'ha;
	// Over-voltage dwell time
	localparam longint OV_DELAY_S = 60;
	localparam longint CLK_HZ = 125000000;
	// Event numbers
	localparam logic [4:0] EV_MODE = 5'h04;
	localparam logic [4:0] EV_CHFAIL = 5'h05;
	localparam logic [4:0] EV_DIAG = 5'h06;
	localparam logic [4:0] EV_ADC = 5'h08;
	localparam logic [4:0] EV_ULTRA = 5'h09;
	localparam logic [4:0] EV_PV1OC = 5'h0a;
	localparam logic [4:0] EV_PVOV = 5'h0b;
	localparam logic [4:0] EV_OUTAOC = 5'h0c;
	localparam logic [4:0] EV_LOWSOC = 5'h0d;
	localparam logic [4:0] EV_LOWBAT = 5'h0e;
	localparam logic [4:0] EV_SURGE = 5'h0f;
	localparam logic [4:0] EV_BATOV = 5'h10;
	// Mode event data codes
	localparam logic [12:0] MD_A_ON = 13'h001;
	localparam logic [12:0] MD_A_OFF = 13'h002;
	localparam logic [12:0] MD_B_ON = 13'h003;
	localparam logic [12:0] MD_B_OFF = 13'h004;
	localparam logic [12:0] MD_A_OPEN = 13'h00a;
	localparam logic [12:0] MD_B_OPEN = 13'h00b;
	// Channel-off sources start as already seen
	localparam logic [16:0] COND_RST = 17'h0000a;
	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_EVT = 4'h8;
	localparam logic [3:0] STEP_RST = 4'h2;
	localparam logic [6:0] RECON_RST = 7'h23;
	typedef struct packed {
		logic [12:0] batt_v;
		logic [12:0] pv_a_v;
		logic [12:0] pv_b_v;
		logic [12:0] pv1_i;
		logic [12:0] outa_i;
		logic [12:0] vref;
		logic [6:0] soc;
	} cpm_meas_t;
	typedef struct packed {
		logic [4:0] num;
		logic [12:0] data;
	} cpm_evt_t;
	typedef struct packed {
		logic batt_open;
		logic load_open;
		logic shutdown;
		logic alarm;
		logic ilim;
	} cpm_act_t;
	typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_HALT} cpm_state_t;
endpackage

// ===== test/cpm_stage_model.sv
/*
 Partner model: sensor front end and power stage switches of the charge monitor.
 Assumes the bench sets target samples and pin levels; all on clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module cpm_stage_model (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire cpm_pkg::cpm_meas_t meas_set_in,
	input wire logic [6:0] pin_set_in,
	input wire cpm_pkg::cpm_act_t act_in,
	output cpm_pkg::cpm_meas_t meas_out,
	output logic [6:0] pin_out,
	output logic diag_done_out
);
	logic [2:0] boot_cnt;
	// Converter samples arrive one cycle late, never reset
	always_ff @(posedge clk_sys_in) begin
		meas_out <= meas_set_in;
	end
	// Pins: cha, chb, pwm min, trip, fuse, self-check fail, battery open
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_out <= 7'h00;
		end else begin
			pin_out <= pin_set_in | {6'h00, act_in.batt_open};
		end
	end
	// Self-check finishes a few cycles after power-up
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			boot_cnt <= 3'h0;
		end else if (boot_cnt != 3'h4) begin
			boot_cnt <= boot_cnt + 3'h1;
		end
	end
	assign diag_done_out = (boot_cnt == 3'h4);
endmodule
`default_nettype wire

// ===== test/tb_cpm_monitor.sv
/*
 Testbench of the charge protection event monitor: bus tasks, event queue, checks.
 Assumes cpm_pkg, cpm_monitor and cpm_stage_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_cpm_monitor;
	logic clk_sys_in, rst_b_in, wb_cyc, wb_stb, wb_we, wb_ack, evt_valid, diag_done;
	logic [3:0] wb_adr, wb_sel;
	logic [31:0] wb_dat, wb_rd, rd, ctrl_val;
	logic [6:0] pin_set, pin;
	logic [1:0] dip;
	logic [6:0] thr_tab [4] = '{7'h19, 7'h32, 7'h4b, 7'h19};
	cpm_pkg::cpm_evt_t evt;
	cpm_pkg::cpm_act_t act;
	cpm_pkg::cpm_meas_t meas_set, meas, nom, m;
	cpm_pkg::cpm_evt_t q [$];
	int miscompares, compares, cycles, i;
	initial begin
		clk_sys_in = 0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	cpm_stage_model i_model (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.meas_set_in(meas_set), .pin_set_in(pin_set), .act_in(act), .meas_out(meas),
		.pin_out(pin), .diag_done_out(diag_done));
	cpm_monitor #(.OV_DLY_CYC(33'd20)) i_dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
		.wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rd), .wb_ack_out(wb_ack),
		.meas_in(meas), .cha_on_in(pin[6]), .chb_on_in(pin[5]), .pwm_min_in(pin[4]),
		.batt_open_in(pin[0]), .hw_trip_in(pin[3]), .fuse_open_in(pin[2]),
		.diag_done_in(diag_done), .diag_fail_in(pin[1]), .dip_in(dip),
		.evt_valid_out(evt_valid), .evt_out(evt), .act_out(act));
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Event collector and run limit
	always @(posedge clk_sys_in) begin
		cycles++;
		if (evt_valid === 1'b1)
			q.push_back(evt);
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	task bad(input string s);
		miscompares++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
			bad($sformatf("value %h wanted %h", got, exp));
	endtask
	task cmp_act(input logic [4:0] exp);
		compares++;
		if (act !== exp)
			bad($sformatf("actions %b wanted %b", act, exp));
	endtask
	task cmp_evt(input logic [4:0] n, input logic [12:0] d);
		cpm_pkg::cpm_evt_t e;
		int k;
		compares++;
		for (k = 0; k < 60 && q.size() == 0; k++)
			@(negedge clk_sys_in);
		if (q.size() == 0) begin
			bad($sformatf("no event %h", n));
		end else begin
			e = q.pop_front();
			if (e !== {n, d})
				bad($sformatf("event %h/%h wanted %h/%h", e.num, e.data, n, d));
		end
	endtask
	task cmp_none;
		repeat (10) @(negedge clk_sys_in);
		cmp_reg(32'(q.size()), 32'h0);
	endtask
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat <= d;
		@(posedge clk_sys_in);
		while (wb_ack !== 1'b1)
			@(posedge clk_sys_in);
		rd = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task restart;
		wb(1'b1, cpm_pkg::REG_CTRL, ctrl_val | 32'h4);
		repeat (8) @(negedge clk_sys_in);
	endtask
	task pin_to(input int b, input logic v);
		@(posedge clk_sys_in);
		pin_set[b] <= v;
	endtask
	task put(input cpm_pkg::cpm_meas_t v);
		@(posedge clk_sys_in);
		meas_set <= v;
	endtask
	task soc(input logic [6:0] v);
		@(posedge clk_sys_in);
		meas_set.soc <= v;
		repeat (5) @(negedge clk_sys_in);
	endtask
	task fault(input logic pwm, input logic [4:0] n1, input logic [12:0] d1,
		input logic [4:0] n2, input logic [12:0] d2, input logic [4:0] a);
		put(m);
		cmp_evt(n1, d1);
		if (n2 != 5'h00)
			cmp_evt(n2, d2);
		repeat (3) @(negedge clk_sys_in);
		if (pwm) begin
			cmp_act(5'h00);
			pin_to(4, 1'b1);
			repeat (5) @(negedge clk_sys_in);
		end
		cmp_act(a);
		pin_to(4, 1'b0);
		put(nom);
		repeat (5) @(negedge clk_sys_in);
		cmp_act(a);
		restart();
		cmp_act(5'h00);
		cmp_none();
	endtask
	task soc_walk(input logic [6:0] thr, input logic [6:0] hi);
		soc(thr + 7'h01);
		cmp_act(5'h00);
		soc(thr);
		cmp_evt(cpm_pkg::EV_LOWSOC, {6'h00, thr});
		cmp_act(5'h08);
		soc(hi - 7'h01);
		cmp_act(5'h08);
		soc(hi);
		cmp_act(5'h00);
		soc(7'h64);
	endtask
	initial begin
		rst_b_in = 0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
		wb_sel = 4'hf;
		nom = '{13'h1f4, 13'h100, 13'h100, 13'h010, 13'h010, 13'h0900, 7'h64};
		meas_set = nom;
		pin_set = 7'h00;
		dip = 2'h0;
		ctrl_val = 32'h00230200;
		repeat (12) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		repeat (10) @(negedge clk_sys_in);
		cmp_act(5'h00);
		wb(1'b0, cpm_pkg::REG_CTRL, 32'h0);
		cmp_reg(rd, 32'h00230200);
		wb(1'b1, 4'hc, 32'hffffffff);
		wb(1'b0, 4'hc, 32'h0);
		cmp_reg(rd, 32'h0);
		cmp_none();
		$display("test reset done");
		pin_to(6, 1'b1);
		cmp_evt(cpm_pkg::EV_MODE, 13'h001);
		pin_to(5, 1'b1);
		cmp_evt(cpm_pkg::EV_MODE, 13'h003);
		pin_to(0, 1'b1);
		cmp_evt(cpm_pkg::EV_MODE, 13'h00a);
		cmp_evt(cpm_pkg::EV_MODE, 13'h00b);
		pin_to(0, 1'b0);
		pin_to(6, 1'b0);
		cmp_evt(cpm_pkg::EV_MODE, 13'h002);
		pin_to(5, 1'b0);
		cmp_evt(cpm_pkg::EV_MODE, 13'h004);
		pin_to(3, 1'b1);
		cmp_evt(cpm_pkg::EV_CHFAIL, 13'h000);
		pin_to(3, 1'b0);
		restart();
		pin_to(2, 1'b1);
		cmp_evt(cpm_pkg::EV_SURGE, 13'h000);
		pin_to(2, 1'b0);
		cmp_none();
		$display("test modes and pins done");
		for (i = 0; i < 2; i++) begin
			m = nom;
			m.vref = (i == 0) ? 13'h07ff : 13'h0a01;
			put(m);
			cmp_evt(cpm_pkg::EV_ADC, m.vref);
			put(nom);
		end
		m = nom;
		m.batt_v = 13'h0cb;
		put(m);
		cmp_none();
		m.batt_v = 13'h0ca;
		fault(1'b0, cpm_pkg::EV_ULTRA, 13'h0ca, cpm_pkg::EV_LOWBAT, 13'h0ca, 5'h16);
		m = nom;
		m.pv1_i = 13'h0c3;
		fault(1'b1, cpm_pkg::EV_PV1OC, 13'h0c3, 5'h00, 13'h0, 5'h07);
		m = nom;
		m.pv_b_v = 13'h13ca;
		fault(1'b1, cpm_pkg::EV_PVOV, 13'h13ca, 5'h00, 13'h0, 5'h16);
		m = nom;
		m.outa_i = 13'h194;
		fault(1'b1, cpm_pkg::EV_OUTAOC, 13'h194, 5'h00, 13'h0, 5'h16);
		m = nom;
		m.batt_v = 13'h289;
		fault(1'b0, cpm_pkg::EV_BATOV, 13'h289, 5'h00, 13'h0, 5'h1e);
		m = nom;
		m.batt_v = 13'h27f;
		put(m);
		repeat (15) @(negedge clk_sys_in);
		cmp_reg(32'(q.size()), 32'h0);
		fault(1'b0, cpm_pkg::EV_BATOV, 13'h27f, 5'h00, 13'h0, 5'h1e);
		pin_to(1, 1'b1);
		restart();
		cmp_evt(cpm_pkg::EV_DIAG, 13'h000);
		repeat (3) @(negedge clk_sys_in);
		cmp_act(5'h16);
		pin_to(1, 1'b0);
		repeat (3) @(negedge clk_sys_in);
		restart();
		cmp_act(5'h00);
		nom.batt_v = 13'h270;
		put(nom);
		ctrl_val = 32'h00230201;
		wb(1'b1, cpm_pkg::REG_CTRL, ctrl_val);
		m = nom;
		m.batt_v = 13'h25f;
		fault(1'b0, cpm_pkg::EV_ULTRA, 13'h25f, 5'h00, 13'h0, 5'h16);
		m.batt_v = 13'h1fa;
		fault(1'b0, cpm_pkg::EV_ULTRA, 13'h1fa, cpm_pkg::EV_LOWBAT, 13'h1fa, 5'h16);
		ctrl_val = 32'h00230200;
		wb(1'b1, cpm_pkg::REG_CTRL, ctrl_val);
		$display("test faults done");
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys_in);
			dip <= 2'(i);
			repeat (5) @(negedge clk_sys_in);
			soc_walk(thr_tab[i], thr_tab[i] + 7'h0a);
		end
		ctrl_val = 32'h003c0402;
		wb(1'b1, cpm_pkg::REG_CTRL, ctrl_val);
		wb(1'b0, cpm_pkg::REG_CTRL, 32'h0);
		cmp_reg(rd, ctrl_val);
		soc_walk(7'h28, 7'h3c);
		cmp_none();
		$display("test charge done");
		end_sim();
	end
endmodule
`default_nettype wire
